// ==== dib_defs.svh ====
`ifndef DIB_DEFS_SVH
`define DIB_DEFS_SVH

// Register word offsets on the plain register port.
`define DIB_REG_CTRL 4'h0
`define DIB_REG_TRIG_FREQ 4'h1
`define DIB_REG_COAST 4'h2
`define DIB_REG_DEC_TORQUE 4'h3
`define DIB_REG_DEC_TIME 4'h4
`define DIB_REG_ACC_TORQUE 4'h5
`define DIB_REG_ACC_TIME 4'h6
`define DIB_REG_PULSE_FREQ 4'h7
`define DIB_REG_STATUS 4'h8

// Control register fields.
`define DIB_CTRL_AUTO_BIT 0
`define DIB_CTRL_MODE_BIT 1

// Codes of the enable and mode settings.
`define DIB_AUTO_OFF 1'h0
`define DIB_AUTO_ON 1'h1
`define DIB_MODE_TIMED 1'h0
`define DIB_MODE_HELD 1'h1

// Reset values and ranges (frequency in 0.01 Hz, times in 0.1 s, pulse in 0.1 kHz).
`define DIB_TRIG_RST 13'h0032
`define DIB_TRIG_MAX 13'h1770
`define DIB_COAST_RST 6'h00
`define DIB_COAST_MAX 6'h32
`define DIB_TORQUE_RST 7'h00
`define DIB_TORQUE_MAX 7'h64
`define DIB_TIME_RST 10'h000
`define DIB_TIME_MAX 10'h258
`define DIB_PF_RST 8'h1e
`define DIB_PF_MIN 8'h05
`define DIB_PF_MAX_SMALL 8'h96
`define DIB_PF_MAX_LARGE 8'h64
`define DIB_PF_KNEE 8'h32
`define DIB_FULL_PCT 7'h64

// Modulation scaling.
`define DIB_PHASE_STEP 20'h00d6c
`define DIB_DUTY_SCALE 25'h0000666

// Time base: one tick is 0.1 s.
`define DIB_TICK_NS 100000000
`define DIB_CLK_NS 8
`define DIB_TICK_CYCLES (`DIB_TICK_NS / `DIB_CLK_NS)

`endif

// ==== dib_pkg.sv ====
`default_nettype none
package dib_pkg;

  typedef enum logic [4:0] {
    dib_st_idle = 5'h01,
    dib_st_coast = 5'h02,
    dib_st_dec_brake = 5'h04,
    dib_st_acc_brake = 5'h08,
    dib_st_release = 5'h10
  } dib_state_t;

endpackage
`default_nettype wire

// ==== dib_mod_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dib_mod_if;
  logic en;
  logic [19:0] step;
  logic [13:0] duty;
  logic pulse;

  modport ctl (
    output en,
    output step,
    output duty,
    input pulse
  );

  modport gen (
    input en,
    input step,
    input duty,
    output pulse
  );
endinterface
`default_nettype wire

// ==== dib_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module dib_timer #(
  parameter int W = 10
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Control.
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic en_i,
  // Status.
  output logic done_o
);

  logic [W-1:0] count_r;

  // Counts down one step per enable and rests at zero.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_r <= '0;
    end else if (load_i) begin
      count_r <= load_val_i;
    end else if (en_i && (count_r != '0)) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign done_o = (count_r == '0);

endmodule
`default_nettype wire

// ==== dib_pwm.sv ====
`timescale 1ns/1ps
`default_nettype none
module dib_pwm (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Modulation control.
  dib_mod_if.gen mod
);

  logic [31:0] phase_r;

  // Phase accumulator sets the braking pulse rate.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_r <= 32'h0;
    end else if (!mod.en) begin
      phase_r <= 32'h0;
    end else begin
      phase_r <= phase_r + {12'h000, mod.step};
    end
  end

  // The pulse is high for the duty fraction of each period.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mod.pulse <= 1'b0;
    end else begin
      mod.pulse <= mod.en && (phase_r[31:18] < mod.duty);
    end
  end

endmodule
`default_nettype wire

// ==== dib_brake_seq.sv ====
// Notes on behaviour
// R1 - Automatic braking enable: 0 keeps it off, 1 turns it on, reset value 0.
// R2 - Automatic braking triggers when output frequency falls below trigger setting, 0..60 Hz.
// R3 - Every deceleration trigger first coasts for the coast delay, 0..5 s.
// R4 - Deceleration braking uses the deceleration torque setting, 0..100 percent.
// R5 - Deceleration braking lasts the deceleration time setting, 0..60 s.
// R6 - Input mode 0: braking ends only when the deceleration time expires.
// R7 - Input mode 1, the default: braking follows the brake input level.
// R8 - The controller issues a stop and raises the brake input for input braking.
// R9 - Braking drives pulsed DC onto the stator instead of alternating output.
// R10 - Before acceleration, brake at the acceleration torque setting, 0..100 percent.
// R11 - Hold pre-acceleration braking for its time, 0..60 s, then release acceleration.
// R12 - Pulse frequency 0.5..15 kHz, or 0.5..10 kHz on large ratings, default 3 kHz.
// R13 - Braking modulation uses its own pulse rate, apart from the run carrier.
// R14 - Relative braking torque falls as pulse frequency rises above 5 kHz.
// R15 - Operators keep braking torques low and braking times short.
// R16 - Idle, coast, brake, release; modulation stops at end; retriggers wait for idle.
//
// Chosen here: the address map and the plain strobed port.
`include "dib_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dib_brake_seq #(
  parameter int TICK_CYCLES = `DIB_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Drive commands and feedback.
  input wire logic run_cmd_i,
  input wire logic brake_request_input_i,
  input wire logic [15:0] actual_freq_i,
  input wire logic large_rating_i,
  // Output stage.
  output logic dc_injection_braking_o,
  output logic coast_o,
  output logic modulation_en_o,
  output logic stator_pulse_o,
  output logic accel_release_o,
  output dib_pkg::dib_state_t state_o
);

  import dib_pkg::*;

  dib_state_t state_r;
  dib_state_t state_nxt;

  logic auto_brake_enable_r;
  logic brake_input_mode_r;
  logic [12:0] brake_trigger_freq_r;
  logic [5:0] coast_delay_r;
  logic [6:0] decel_brake_torque_r;
  logic [9:0] decel_brake_time_r;
  logic [6:0] accel_brake_torque_r;
  logic [9:0] accel_brake_time_r;
  logic [7:0] brake_pulse_freq_r;
  logic large_rating_r;
  logic strap_done_r;
  logic run_d_r;
  logic start_pend_r;
  logic cause_input_r;
  logic cause_input_nxt;
  logic [15:0] rdata_nxt;

  logic stop_w;
  logic input_trig_w;
  logic auto_trig_w;
  logic start_edge_w;
  logic start_take_w;
  logic dur_load_w;
  logic [9:0] dur_val_w;
  logic dur_done_w;
  logic tick_w;
  logic held_mode_w;

  logic [7:0] pf_max_w;
  logic [7:0] pf_eff_w;
  logic [6:0] derate_pct_w;
  logic [6:0] torque_sel_w;
  logic [13:0] torque_prod_w;
  logic [24:0] duty_scaled_w;
  logic [19:0] step_w;
  logic braking_nxt;

  dib_mod_if mod ();

  // Register writes, clamped to the legal setting ranges; pulse frequency to 0.5..15 kHz whatever the rating.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      auto_brake_enable_r <= `DIB_AUTO_OFF; // R1
      brake_input_mode_r <= `DIB_MODE_HELD; // R7
      brake_trigger_freq_r <= `DIB_TRIG_RST; // R2
      coast_delay_r <= `DIB_COAST_RST;
      decel_brake_torque_r <= `DIB_TORQUE_RST;
      decel_brake_time_r <= `DIB_TIME_RST;
      accel_brake_torque_r <= `DIB_TORQUE_RST;
      accel_brake_time_r <= `DIB_TIME_RST;
      brake_pulse_freq_r <= `DIB_PF_RST; // R12
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `DIB_REG_CTRL: begin
          auto_brake_enable_r <= reg_wdata_i[`DIB_CTRL_AUTO_BIT]; // R1
          brake_input_mode_r <= reg_wdata_i[`DIB_CTRL_MODE_BIT];
        end
        `DIB_REG_TRIG_FREQ: begin
          brake_trigger_freq_r <= (reg_wdata_i > {3'h0, `DIB_TRIG_MAX}) ? `DIB_TRIG_MAX :
                                  reg_wdata_i[12:0]; // R2
        end
        `DIB_REG_COAST: begin
          coast_delay_r <= (reg_wdata_i > {10'h000, `DIB_COAST_MAX}) ? `DIB_COAST_MAX :
                           reg_wdata_i[5:0]; // R3
        end
        `DIB_REG_DEC_TORQUE: begin
          decel_brake_torque_r <= (reg_wdata_i > {9'h000, `DIB_TORQUE_MAX}) ? `DIB_TORQUE_MAX :
                                  reg_wdata_i[6:0]; // R4
        end
        `DIB_REG_DEC_TIME: begin
          decel_brake_time_r <= (reg_wdata_i > {6'h00, `DIB_TIME_MAX}) ? `DIB_TIME_MAX :
                                reg_wdata_i[9:0]; // R5
        end
        `DIB_REG_ACC_TORQUE: begin
          accel_brake_torque_r <= (reg_wdata_i > {9'h000, `DIB_TORQUE_MAX}) ? `DIB_TORQUE_MAX :
                                  reg_wdata_i[6:0]; // R10
        end
        `DIB_REG_ACC_TIME: begin
          accel_brake_time_r <= (reg_wdata_i > {6'h00, `DIB_TIME_MAX}) ? `DIB_TIME_MAX :
                                reg_wdata_i[9:0]; // R11
        end
        `DIB_REG_PULSE_FREQ: begin
          if (reg_wdata_i < {8'h00, `DIB_PF_MIN}) begin
            brake_pulse_freq_r <= `DIB_PF_MIN; // R12
          end else if (reg_wdata_i > {8'h00, `DIB_PF_MAX_SMALL}) begin
            brake_pulse_freq_r <= `DIB_PF_MAX_SMALL;
          end else begin
            brake_pulse_freq_r <= reg_wdata_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Power rating strap is caught once after reset release.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      large_rating_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      large_rating_r <= large_rating_i;
      strap_done_r <= 1'b1;
    end
  end

  // Read data stand for one cycle after the read strobe.
  always_comb begin
    rdata_nxt = 16'h0000;
    case (reg_addr_i)
      `DIB_REG_CTRL: rdata_nxt = {14'h0000, brake_input_mode_r, auto_brake_enable_r};
      `DIB_REG_TRIG_FREQ: rdata_nxt = {3'h0, brake_trigger_freq_r};
      `DIB_REG_COAST: rdata_nxt = {10'h000, coast_delay_r};
      `DIB_REG_DEC_TORQUE: rdata_nxt = {9'h000, decel_brake_torque_r};
      `DIB_REG_DEC_TIME: rdata_nxt = {6'h00, decel_brake_time_r};
      `DIB_REG_ACC_TORQUE: rdata_nxt = {9'h000, accel_brake_torque_r};
      `DIB_REG_ACC_TIME: rdata_nxt = {6'h00, accel_brake_time_r};
      `DIB_REG_PULSE_FREQ: rdata_nxt = {8'h00, brake_pulse_freq_r};
      `DIB_REG_STATUS: begin
        rdata_nxt = {7'h00, cause_input_r, start_pend_r, (pf_eff_w > `DIB_PF_KNEE), large_rating_r, state_r};
      end
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // Trigger conditions; input braking needs a stop plus the brake input.
  assign stop_w = !run_cmd_i;
  assign input_trig_w = stop_w && brake_request_input_i; // R8
  assign auto_trig_w = (auto_brake_enable_r == `DIB_AUTO_ON) && stop_w &&
                       (actual_freq_i < {3'h0, brake_trigger_freq_r}); // R2
  assign held_mode_w = cause_input_r && (brake_input_mode_r == `DIB_MODE_HELD);
  assign start_edge_w = run_cmd_i && !run_d_r;
  assign start_take_w = (state_r == dib_st_idle) && start_pend_r;

  // A start request is kept until the sequencer is idle to take it.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_d_r <= 1'b0;
      start_pend_r <= 1'b0;
    end else begin
      run_d_r <= run_cmd_i;
      if (start_edge_w) begin
        start_pend_r <= 1'b1; // R16
      end else if (start_take_w) begin
        start_pend_r <= 1'b0;
      end
    end
  end

  // Sequencer next state.
  always_comb begin
    state_nxt = state_r;
    cause_input_nxt = cause_input_r;
    dur_load_w = 1'b0;
    dur_val_w = 10'h000;
    case (state_r)
      dib_st_idle: begin
        if (start_pend_r) begin
          state_nxt = dib_st_acc_brake; // R10
          dur_load_w = 1'b1;
          dur_val_w = accel_brake_time_r; // R11
        end else if (input_trig_w || auto_trig_w) begin
          state_nxt = dib_st_coast; // R3
          cause_input_nxt = input_trig_w;
          dur_load_w = 1'b1;
          dur_val_w = {4'h0, coast_delay_r}; // R3
        end
      end
      dib_st_coast: begin
        if (held_mode_w && !brake_request_input_i) begin
          state_nxt = dib_st_release; // R7
        end else if (dur_done_w) begin
          state_nxt = dib_st_dec_brake;
          dur_load_w = 1'b1;
          dur_val_w = decel_brake_time_r; // R5
        end
      end
      dib_st_dec_brake: begin
        if (held_mode_w) begin
          if (!brake_request_input_i) begin
            state_nxt = dib_st_release; // R7
          end
        end else if (dur_done_w) begin
          state_nxt = dib_st_release; // R6
        end
      end
      dib_st_acc_brake: begin
        if (dur_done_w) begin
          state_nxt = dib_st_release; // R11
        end
      end
      dib_st_release: begin
        if (!input_trig_w && !auto_trig_w) begin
          state_nxt = dib_st_idle; // R16
        end
      end
      default: begin
        state_nxt = dib_st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= dib_st_idle;
      cause_input_r <= 1'b0;
    end else begin
      state_r <= state_nxt; // R16
      cause_input_r <= cause_input_nxt;
    end
  end

  // Tick prescaler restarts with every duration load so durations are exact.
  dib_timer #(
    .W(24)
  ) u_tick (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(tick_w || dur_load_w),
    .load_val_i(24'(TICK_CYCLES - 1)),
    .en_i(1'b1),
    .done_o(tick_w)
  );

  // Duration counter in 0.1 s ticks for coast and braking times.
  dib_timer #(
    .W(10)
  ) u_dur (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .load_i(dur_load_w),
    .load_val_i(dur_val_w),
    .en_i(tick_w && !dur_load_w),
    .done_o(dur_done_w)
  );

  // Pulse rate limited by the rating, and torque derated above the knee.
  assign pf_max_w = large_rating_r ? `DIB_PF_MAX_LARGE : `DIB_PF_MAX_SMALL; // R12
  assign pf_eff_w = (brake_pulse_freq_r > pf_max_w) ? pf_max_w : brake_pulse_freq_r;
  assign derate_pct_w = (pf_eff_w > `DIB_PF_KNEE) ?
                        (`DIB_FULL_PCT - 7'((pf_eff_w - `DIB_PF_KNEE) >> 1)) : `DIB_FULL_PCT; // R14
  assign torque_sel_w = (state_nxt == dib_st_acc_brake) ? accel_brake_torque_r :
                        decel_brake_torque_r; // R4 R10
  assign torque_prod_w = {7'h00, torque_sel_w} * {7'h00, derate_pct_w}; // R14
  assign duty_scaled_w = {11'h000, torque_prod_w} * `DIB_DUTY_SCALE;
  assign step_w = {12'h000, pf_eff_w} * `DIB_PHASE_STEP; // R13
  assign braking_nxt = (state_nxt == dib_st_dec_brake) || (state_nxt == dib_st_acc_brake);

  // Modulation settings for the braking pulse generator.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mod.en <= 1'b0;
      mod.step <= 20'h00000;
      mod.duty <= 14'h0000;
    end else begin
      mod.en <= braking_nxt; // R9 R16
      mod.step <= step_w; // R13
      mod.duty <= duty_scaled_w[23:10];
    end
  end

  dib_pwm u_pwm (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .mod(mod.gen)
  );

  // Output stage drive.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dc_injection_braking_o <= 1'b0;
      coast_o <= 1'b0;
      modulation_en_o <= 1'b0;
      stator_pulse_o <= 1'b0;
      accel_release_o <= 1'b0;
      state_o <= dib_st_idle;
    end else begin
      dc_injection_braking_o <= braking_nxt;
      coast_o <= (state_nxt == dib_st_coast);
      modulation_en_o <= mod.en;
      stator_pulse_o <= mod.en && mod.pulse; // R9
      accel_release_o <= (state_r == dib_st_acc_brake) && (state_nxt == dib_st_release); // R11
      state_o <= state_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== dib_brake_seq_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dib_brake_seq_asserts #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register port.
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Output stage.
  input wire logic dc_injection_braking_o,
  input wire logic coast_o,
  input wire logic modulation_en_o,
  input wire logic stator_pulse_o,
  input wire logic accel_release_o,
  input wire dib_pkg::dib_state_t state_o
);
  import dib_pkg::*;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_brake_off3;
    !dc_injection_braking_o [*3];
  endsequence
  sequence s_release_pulse;
    ($past(state_o) == dib_st_acc_brake) ##1 !accel_release_o;
  endsequence

  property p_onehot_state;
    $onehot(state_o);
  endproperty
  property p_coast_out;
    state_o == dib_st_coast |-> coast_o && !dc_injection_braking_o;
  endproperty
  property p_brake_out;
    dc_injection_braking_o == (state_o inside {dib_st_dec_brake, dib_st_acc_brake});
  endproperty
  property p_dec_after_coast;
    $rose(state_o == dib_st_dec_brake) |-> $past(state_o) == dib_st_coast;
  endproperty
  property p_acc_from_idle;
    $rose(state_o == dib_st_acc_brake) |-> $past(state_o) == dib_st_idle;
  endproperty
  property p_mod_follows;
    modulation_en_o == $past(dc_injection_braking_o);
  endproperty
  property p_pulse_gated;
    stator_pulse_o |-> modulation_en_o || $past(modulation_en_o);
  endproperty
  property p_mod_stops;
    s_brake_off3 |-> !stator_pulse_o && !modulation_en_o;
  endproperty
  property p_release_pulse;
    accel_release_o |-> s_release_pulse;
  endproperty
  property p_read_quiet;
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000;
  endproperty

  a_onehot_state: assert property (p_onehot_state) else $error("state not one-hot");
  a_coast_out: assert property (p_coast_out) else $error("coast output wrong");
  a_brake_out: assert property (p_brake_out) else $error("braking output wrong");
  a_dec_after_coast: assert property (p_dec_after_coast) else $error("braking skipped coast");
  a_acc_from_idle: assert property (p_acc_from_idle) else $error("pre-accel not from idle");
  a_mod_follows: assert property (p_mod_follows) else $error("modulation enable lag wrong");
  a_pulse_gated: assert property (p_pulse_gated) else $error("stator pulse outside braking");
  a_mod_stops: assert property (p_mod_stops) else $error("modulation not stopped");
  a_release_pulse: assert property (p_release_pulse) else $error("release pulse wrong");
  a_read_quiet: assert property (p_read_quiet) else $error("read data without read");
endmodule
bind dib_brake_seq dib_brake_seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
  .mclk_i(mclk_i),
  .rst_b_i(rst_b_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .dc_injection_braking_o(dc_injection_braking_o),
  .coast_o(coast_o),
  .modulation_en_o(modulation_en_o),
  .stator_pulse_o(stator_pulse_o),
  .accel_release_o(accel_release_o),
  .state_o(state_o)
);
`default_nettype wire

// ==== dib_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dib_stage_model (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Motor state.
  input wire logic run_cmd_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  output logic [15:0] freq_o,
  // Stator drive.
  input wire logic modulation_en_i,
  input wire logic stator_pulse_i,
  output int pulse_cnt_o,
  output int stray_cnt_o
);
  logic pulse_r;
  logic mod_r;

  // The motor slows down after a stop until it stands.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      freq_o <= 16'h0000;
    end else if (load_i) begin
      freq_o <= load_val_i;
    end else if (!run_cmd_i && freq_o != 16'h0000) begin
      freq_o <= freq_o - 16'h0001;
    end
  end

  // Pulses on the stator are counted; a pulse without modulation is stray.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_r <= 1'b0;
      mod_r <= 1'b0;
      pulse_cnt_o <= 0;
      stray_cnt_o <= 0;
    end else begin
      pulse_r <= stator_pulse_i;
      mod_r <= modulation_en_i;
      if (stator_pulse_i && !pulse_r) begin
        pulse_cnt_o <= pulse_cnt_o + 1;
      end
      if (stator_pulse_i && !modulation_en_i && !mod_r) begin
        stray_cnt_o <= stray_cnt_o + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dc_injection_brake_sequencer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module dc_injection_brake_sequencer_test;
  import dib_pkg::*;
  localparam int TC = 100;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic run_cmd_i = 1'b0;
  logic brake_request_input_i = 1'b0;
  logic large_rating_i = 1'b0;
  logic load_i = 1'b0;
  logic [15:0] load_val_i = 16'h0000;
  wire logic [15:0] reg_rdata_o;
  wire logic [15:0] actual_freq_i;
  wire logic dc_injection_braking_o;
  wire logic coast_o;
  wire logic modulation_en_o;
  wire logic stator_pulse_o;
  wire logic accel_release_o;
  dib_state_t state_o;
  int pulse_cnt;
  int stray_cnt;
  int fail_count = 0;
  int comparisons = 0;
  logic [15:0] rdv;
  logic [15:0] rst_tab [8] = '{16'h0002, 16'h0032, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h001e};

  always #4 mclk_i = ~mclk_i;

  dib_brake_seq #(.TICK_CYCLES(TC)) DUT (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .run_cmd_i(run_cmd_i),
    .brake_request_input_i(brake_request_input_i),
    .actual_freq_i(actual_freq_i),
    .large_rating_i(large_rating_i),
    .dc_injection_braking_o(dc_injection_braking_o),
    .coast_o(coast_o),
    .modulation_en_o(modulation_en_o),
    .stator_pulse_o(stator_pulse_o),
    .accel_release_o(accel_release_o),
    .state_o(state_o)
  );

  dib_stage_model u_stage (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .run_cmd_i(run_cmd_i),
    .load_i(load_i),
    .load_val_i(load_val_i),
    .freq_o(actual_freq_i),
    .modulation_en_i(modulation_en_o),
    .stator_pulse_i(stator_pulse_o),
    .pulse_cnt_o(pulse_cnt),
    .stray_cnt_o(stray_cnt)
  );

  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    rdv = reg_rdata_o;
  endtask

  task automatic ld(input logic [15:0] v);
    @(posedge mclk_i);
    load_val_i <= v;
    load_i <= 1'b1;
    @(posedge mclk_i);
    load_i <= 1'b0;
  endtask

  task automatic wait_st(input dib_state_t s);
    int i;
    for (i = 0; i < 1000 && state_o !== s; i++) @(posedge mclk_i);
    `CHK("state reached", s, state_o)
  endtask

  // Counts the cycles spent in a state, optionally dropping the brake input.
  task automatic span(input dib_state_t s, input int exp, input int drop);
    int n;
    wait_st(s);
    n = 0;
    while (state_o === s && n < 20000) begin
      if (n == drop) brake_request_input_i <= 1'b0;
      n++;
      @(posedge mclk_i);
    end
    `CHK("state span", 1'b1, (n >= exp && n <= exp + 2))
  endtask

  initial begin
    repeat (60000) @(posedge mclk_i);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    foreach (rst_tab[i]) begin
      rd(i[3:0]);
      `CHK("reset value", rst_tab[i], rdv)
    end
    rd(4'h8);
    `CHK("status", 16'h0001, rdv)
    rd(4'hf);
    `CHK("unmapped", 16'h0000, rdv)
    $display("test reset values done");
    wr(4'h1, 16'hffff);
    rd(4'h1);
    `CHK("trigger clamp", 16'h1770, rdv)
    wr(4'h7, 16'h0001);
    rd(4'h7);
    `CHK("pulse min", 16'h0005, rdv)
    wr(4'h7, 16'hffff);
    rd(4'h7);
    `CHK("pulse max", 16'h0096, rdv)
    wr(4'h3, 16'hffff);
    rd(4'h3);
    `CHK("torque clamp", 16'h0064, rdv)
    wr(4'h7, 16'h0033);
    rd(4'h8);
    `CHK("derating on", 1'b1, rdv[6])
    wr(4'h7, 16'h0032);
    rd(4'h8);
    `CHK("derating off", 1'b0, rdv[6])
    wr(4'h1, 16'h0032);
    wr(4'h3, 16'h0000);
    $display("test clamping done");
    ld(16'h0028);
    repeat (100) @(posedge mclk_i);
    `CHK("auto off idle", dib_st_idle, state_o)
    wr(4'h4, 16'h0001);
    ld(16'h0064);
    wr(4'h0, 16'h0001);
    wait_st(dib_st_coast);
    `CHK("trigger freq", 1'b1, (actual_freq_i < 16'd50 && actual_freq_i >= 16'd45))
    span(dib_st_dec_brake, TC, -1);
    wr(4'h0, 16'h0000);
    wait_st(dib_st_idle);
    $display("test auto braking done");
    wr(4'h2, 16'h0001);
    wr(4'h4, 16'h0002);
    @(posedge mclk_i);
    brake_request_input_i <= 1'b1;
    span(dib_st_coast, TC, -1);
    span(dib_st_dec_brake, 2 * TC, 50);
    wait_st(dib_st_idle);
    $display("test timed input done");
    wr(4'h0, 16'h0002);
    wr(4'h2, 16'h0000);
    wr(4'h4, 16'h0000);
    wr(4'h3, 16'h0032);
    wr(4'h7, 16'h0096);
    @(posedge mclk_i);
    brake_request_input_i <= 1'b1;
    span(dib_st_dec_brake, 9000, 9000);
    `CHK("pulses seen", 1'b1, (pulse_cnt > 0))
    `CHK("stray pulses", 1'b1, (stray_cnt == 0))
    wait_st(dib_st_idle);
    $display("test held input done");
    wr(4'h5, 16'h000a);
    wr(4'h6, 16'h0003);
    @(posedge mclk_i);
    run_cmd_i <= 1'b1;
    span(dib_st_acc_brake, 3 * TC, -1);
    `CHK("accel release", 1'b1, accel_release_o)
    wait_st(dib_st_idle);
    $display("test pre-accel done");
    run_cmd_i <= 1'b0;
    large_rating_i <= 1'b1;
    rst_b_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(4'h8);
    `CHK("large strap", 16'h0021, rdv)
    rd(4'h0);
    `CHK("ctrl after reset", 16'h0002, rdv)
    $display("test strap done");
    end_sim();
  end
endmodule
`default_nettype wire
